/* File: hw/sarrd_device.sv */
// Purpose: Converter end: sample on select fall, shift result on serial clock
// Assumes: Select and serial clock arrive as pins and are synchronised here
// Notes:   Pin reaction has a few cycles of latency; host paces the clock slowly
`timescale 1ns/100ps
`default_nettype none
module sarrd_device (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               nrst,
    // Link
    sarrd_link_if.device                            link,
    // Converter settings and analog stand-in
    input  wire sarrd_pkg::sarrd_res_t              variant,
    input  wire logic [sarrd_pkg::RES_BITS-1:0]     sample_value,
    input  wire logic                               power_down,
    // Status
    output logic                                    awake,
    output logic                                    converting,
    output logic                                    sample_taken
);

    typedef enum logic [2:0] {
        DEV_ASLEEP,
        DEV_WAKING,
        DEV_IDLE,
        DEV_SHIFT,
        DEV_DONE
    } sarrd_dev_state_t;

    // Pin synchronisers and filtered levels
    logic [sarrd_pkg::SYNC_W-1:0] sel_sync_reg;
    logic [sarrd_pkg::SYNC_W-1:0] sel_sync_next;
    logic [sarrd_pkg::SYNC_W-1:0] clk_sync_reg;
    logic [sarrd_pkg::SYNC_W-1:0] clk_sync_next;
    logic                         sel_lvl_reg;
    logic                         sel_lvl_next;
    logic                         sclk_lvl_reg;
    logic                         sclk_lvl_next;
    logic                         sel_fall;
    logic                         sel_rise;
    logic                         sclk_fall;

    // Conversion state
    sarrd_dev_state_t                   state_reg;
    sarrd_dev_state_t                   state_next;
    logic [sarrd_pkg::FRAME_BITS-1:0]   shift_reg;
    logic [sarrd_pkg::FRAME_BITS-1:0]   shift_next;
    logic [sarrd_pkg::LEN_W-1:0]        edge_cnt_reg;
    logic [sarrd_pkg::LEN_W-1:0]        edge_cnt_next;
    logic [sarrd_pkg::LEN_W-1:0]        len_reg;
    logic [sarrd_pkg::LEN_W-1:0]        len_next;
    logic [sarrd_pkg::WAKE_W-1:0]       wake_cnt_reg;
    logic [sarrd_pkg::WAKE_W-1:0]       wake_cnt_next;
    logic                               sdo_reg;
    logic                               sdo_next;
    logic                               oe_reg;
    logic                               oe_next;
    logic                               awake_reg;
    logic                               awake_next;
    logic                               conv_reg;
    logic                               conv_next;
    logic                               taken_reg;
    logic                               taken_next;

    // Three flops per pin; a level changes once the second and third agree
    always_comb begin
        sel_sync_next = {sel_sync_reg[1:0], link.select_n};
        clk_sync_next = {clk_sync_reg[1:0], link.serial_clk};
        sel_lvl_next  = sel_lvl_reg;
        sclk_lvl_next = sclk_lvl_reg;
        if (sel_sync_reg[1] == sel_sync_reg[2]) begin
            sel_lvl_next = sel_sync_reg[2];
        end
        if (clk_sync_reg[1] == clk_sync_reg[2]) begin
            sclk_lvl_next = clk_sync_reg[2];
        end
        // Edges taken early from the next level to save a cycle of latency
        sel_fall  = sel_lvl_reg & ~sel_lvl_next;
        sel_rise  = ~sel_lvl_reg & sel_lvl_next;
        sclk_fall = sclk_lvl_reg & ~sclk_lvl_next;
    end

    // Synchroniser registers; idle link levels are high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_sync_reg <= 3'h7;
            clk_sync_reg <= 3'h7;
            sel_lvl_reg  <= 1'h1;
            sclk_lvl_reg <= 1'h1;
        end else begin
            sel_sync_reg <= sel_sync_next;
            clk_sync_reg <= clk_sync_next;
            sel_lvl_reg  <= sel_lvl_next;
            sclk_lvl_reg <= sclk_lvl_next;
        end
    end

    // Conversion sequencer, paced by select edges, serial clock falls and the wake count
    always_comb begin
        state_next    = state_reg;
        shift_next    = shift_reg;
        edge_cnt_next = edge_cnt_reg;
        len_next      = len_reg;
        wake_cnt_next = wake_cnt_reg;
        sdo_next      = sdo_reg;
        oe_next       = oe_reg;
        taken_next    = 1'h0;
        case (state_reg)
            DEV_ASLEEP: begin
                oe_next = 1'h0;
                if (!power_down) begin
                    wake_cnt_next = '0;
                    state_next    = DEV_WAKING;
                end
            end
            DEV_WAKING: begin
                // Fixed wake count, equal to the allowed delay in cycles
                wake_cnt_next = wake_cnt_reg + 5'h01;
                if (wake_cnt_reg == sarrd_pkg::WAKE_LAST) begin
                    state_next = DEV_IDLE;
                end
            end
            DEV_IDLE: begin
                if (sel_fall) begin
                    // Hold the input and start converting at once
                    shift_next    = sarrd_pkg::sarrd_frame(variant, sample_value);
                    len_next      = sarrd_pkg::sarrd_conv_len(variant);
                    edge_cnt_next = '0;
                    sdo_next      = shift_next[sarrd_pkg::FRAME_BITS-1];
                    oe_next       = 1'h1;
                    taken_next    = 1'h1;
                    state_next    = DEV_SHIFT;
                end
            end
            DEV_SHIFT: begin
                if (sel_rise) begin
                    // Select ended the frame early: let go of the line
                    oe_next    = 1'h0;
                    sdo_next   = 1'h0;
                    state_next = DEV_IDLE;
                end else if (sclk_fall) begin
                    edge_cnt_next = edge_cnt_reg + sarrd_pkg::LEN_ONE;
                    if (edge_cnt_next == len_reg) begin
                        oe_next    = 1'h0;
                        sdo_next   = 1'h0;
                        state_next = DEV_DONE;
                    end else begin
                        shift_next = {shift_reg[sarrd_pkg::FRAME_BITS-2:0], 1'h0};
                        sdo_next   = shift_reg[sarrd_pkg::FRAME_BITS-2];
                    end
                end
            end
            DEV_DONE: begin
                // Extra clocks are ignored until select goes high again
                if (sel_rise) begin
                    state_next = DEV_IDLE;
                end
            end
            default: begin
                oe_next    = 1'h0;
                state_next = DEV_ASLEEP;
            end
        endcase
        // Power-down wins over everything but the sample_taken pulse and releases the line
        if (power_down) begin
            oe_next    = 1'h0;
            sdo_next   = 1'h0;
            state_next = DEV_ASLEEP;
        end
        awake_next = (state_next != DEV_ASLEEP) && (state_next != DEV_WAKING);
        conv_next  = (state_next == DEV_SHIFT);
    end

    // Sequencer registers; reset starts asleep with the line released
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= DEV_ASLEEP;
            shift_reg    <= '0;
            edge_cnt_reg <= '0;
            len_reg      <= sarrd_pkg::LEN_12;
            wake_cnt_reg <= '0;
            sdo_reg      <= 1'h0;
            oe_reg       <= 1'h0;
            awake_reg    <= 1'h0;
            conv_reg     <= 1'h0;
            taken_reg    <= 1'h0;
        end else begin
            state_reg    <= state_next;
            shift_reg    <= shift_next;
            edge_cnt_reg <= edge_cnt_next;
            len_reg      <= len_next;
            wake_cnt_reg <= wake_cnt_next;
            sdo_reg      <= sdo_next;
            oe_reg       <= oe_next;
            awake_reg    <= awake_next;
            conv_reg     <= conv_next;
            taken_reg    <= taken_next;
        end
    end

    // Outputs come straight from flops
    assign link.serial_result_out = sdo_reg;
    assign link.serial_result_oe  = oe_reg;
    assign awake                  = awake_reg;
    assign converting             = conv_reg;
    assign sample_taken           = taken_reg;

endmodule
`default_nettype wire

/* File: hw/sarrd_host.sv */
// Purpose: Host end: frames one conversion per start and collects the result
// Assumes: Serial clock is divided from clk; result line is a synchronised pin
// Notes:   Slow clock covers the converter's synchroniser latency
`timescale 1ns/100ps
`default_nettype none
module sarrd_host (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               nrst,
    // Link
    sarrd_link_if.host                              link,
    // Request
    input  wire logic                               start,
    input  wire sarrd_pkg::sarrd_res_t              variant,
    // Answer
    output logic [sarrd_pkg::RES_BITS-1:0]          result,
    output logic                                    result_valid,
    output logic                                    busy
);

    typedef enum logic [2:0] {
        H_IDLE,
        H_SETUP,
        H_LOW,
        H_HIGH,
        H_TAIL,
        H_GAP
    } sarrd_host_state_t;

    sarrd_host_state_t                state_reg;
    sarrd_host_state_t                state_next;
    logic [sarrd_pkg::SYNC_W-1:0]     din_sync_reg;
    logic [sarrd_pkg::SYNC_W-1:0]     din_sync_next;
    logic                             din_lvl_reg;
    logic                             din_lvl_next;
    logic [sarrd_pkg::CNT_W-1:0]      cnt_reg;
    logic [sarrd_pkg::CNT_W-1:0]      cnt_next;
    logic [sarrd_pkg::LEN_W-1:0]      edge_cnt_reg;
    logic [sarrd_pkg::LEN_W-1:0]      edge_cnt_next;
    logic [sarrd_pkg::LEN_W-1:0]      len_reg;
    logic [sarrd_pkg::LEN_W-1:0]      len_next;
    sarrd_pkg::sarrd_res_t            var_reg;
    sarrd_pkg::sarrd_res_t            var_next;
    logic [sarrd_pkg::FRAME_BITS-1:0] shift_reg;
    logic [sarrd_pkg::FRAME_BITS-1:0] shift_next;
    logic [sarrd_pkg::RES_BITS-1:0]   result_reg;
    logic [sarrd_pkg::RES_BITS-1:0]   result_next;
    logic                             sel_n_reg;
    logic                             sel_n_next;
    logic                             sclk_reg;
    logic                             sclk_next;
    logic                             valid_reg;
    logic                             valid_next;
    logic                             busy_reg;
    logic                             busy_next;
    logic                             half_done;

    // Frame sequencer; a released line reads as zero
    always_comb begin
        din_sync_next = {din_sync_reg[1:0], link.serial_result_oe & link.serial_result_out};
        din_lvl_next  = din_lvl_reg;
        if (din_sync_reg[1] == din_sync_reg[2]) begin
            din_lvl_next = din_sync_reg[2];
        end
        state_next    = state_reg;
        cnt_next      = cnt_reg + sarrd_pkg::CNT_ONE;
        edge_cnt_next = edge_cnt_reg;
        len_next      = len_reg;
        var_next      = var_reg;
        shift_next    = shift_reg;
        result_next   = result_reg;
        sel_n_next    = sel_n_reg;
        sclk_next     = sclk_reg;
        valid_next    = 1'h0;
        half_done     = (cnt_reg == sarrd_pkg::HALF_CYC - sarrd_pkg::CNT_ONE);
        case (state_reg)
            H_IDLE: begin
                cnt_next = '0;
                if (start) begin
                    sel_n_next    = 1'h0;
                    var_next      = variant;
                    len_next      = sarrd_pkg::sarrd_conv_len(variant);
                    edge_cnt_next = '0;
                    state_next    = H_SETUP;
                end
            end
            H_SETUP, H_HIGH: begin
                // Take the bit just before each falling clock
                if (half_done) begin
                    shift_next    = {shift_reg[sarrd_pkg::FRAME_BITS-2:0], din_lvl_reg};
                    sclk_next     = 1'h0;
                    edge_cnt_next = edge_cnt_reg + sarrd_pkg::LEN_ONE;
                    cnt_next      = '0;
                    state_next    = H_LOW;
                end
            end
            H_LOW: begin
                if (half_done) begin
                    sclk_next  = 1'h1;
                    cnt_next   = '0;
                    state_next = (edge_cnt_reg == len_reg) ? H_TAIL : H_HIGH;
                end
            end
            H_TAIL: begin
                // Final half period, then end the frame
                if (half_done) begin
                    sel_n_next  = 1'h1;
                    result_next = sarrd_pkg::sarrd_result(var_reg, shift_reg);
                    valid_next  = 1'h1;
                    cnt_next    = '0;
                    state_next  = H_GAP;
                end
            end
            H_GAP: begin
                // Covers acquisition plus quiet time after the release
                if (cnt_reg == sarrd_pkg::GAP_CYC - sarrd_pkg::CNT_ONE) begin
                    state_next = H_IDLE;
                end
            end
            default: begin
                sel_n_next = 1'h1;
                sclk_next  = 1'h1;
                state_next = H_IDLE;
            end
        endcase
        busy_next = (state_next != H_IDLE);
    end

    // Registers; select and clock idle high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= H_IDLE;
            din_sync_reg <= '0;
            din_lvl_reg  <= 1'h0;
            cnt_reg      <= '0;
            edge_cnt_reg <= '0;
            len_reg      <= sarrd_pkg::LEN_12;
            var_reg      <= sarrd_pkg::SARRD_RES_12;
            shift_reg    <= '0;
            result_reg   <= '0;
            sel_n_reg    <= 1'h1;
            sclk_reg     <= 1'h1;
            valid_reg    <= 1'h0;
            busy_reg     <= 1'h0;
        end else begin
            state_reg    <= state_next;
            din_sync_reg <= din_sync_next;
            din_lvl_reg  <= din_lvl_next;
            cnt_reg      <= cnt_next;
            edge_cnt_reg <= edge_cnt_next;
            len_reg      <= len_next;
            var_reg      <= var_next;
            shift_reg    <= shift_next;
            result_reg   <= result_next;
            sel_n_reg    <= sel_n_next;
            sclk_reg     <= sclk_next;
            valid_reg    <= valid_next;
            busy_reg     <= busy_next;
        end
    end

    assign link.select_n   = sel_n_reg;
    assign link.serial_clk = sclk_reg;
    assign result          = result_reg;
    assign result_valid    = valid_reg;
    assign busy            = busy_reg;

endmodule
`default_nettype wire

/* File: hw/sarrd_link_if.sv */
// Purpose: Select, serial clock and result line between host and converter
// Assumes: Both ends on one clock; the host masks the shared data wire with serial_result_oe
// Notes:   serial_result_oe high means the converter drives the line
`timescale 1ns/100ps
`default_nettype none
interface sarrd_link_if;
    logic select_n;
    logic serial_clk;
    logic serial_result_out;
    logic serial_result_oe;

    // Converter end
    modport device (
        input  select_n,
        input  serial_clk,
        output serial_result_out,
        output serial_result_oe
    );

    // Host end
    modport host (
        output select_n,
        output serial_clk,
        input  serial_result_out,
        input  serial_result_oe
    );
endinterface
`default_nettype wire

/* File: hw/sarrd_pkg.sv */
// Purpose: Shared constants, types and helpers for the serial ADC readout link
// Assumes: One 25 MHz clock on both ends; serial clock made by the host end
// Notes:   Times are kept in ns, cycle counts are derived from them
//
// What this block does
// - Host serial clock between 10 kHz and 20 MHz.
// - Host waits 50 ns quiet after release.
// - Device ready within 1 us after wake.
// - Host allows 250 ns acquisition between conversions.
// - Sample cycle: setup, 16 clocks (14 or 12 at 10/8 bits), acquisition.
// - Output driven 4 cycles (160 ns) after select fall; the printed limit is 22 ns.
// - Each next bit follows a falling clock.
// - Output released after the final falling clock.
// - Select fall samples input, starts conversion.
// - Four leading zeros, MSB first, zero padded.
// - Serial clock paces the conversion itself.
package sarrd_pkg;

    // Clock of both ends
    localparam int unsigned CLK_PERIOD_NS = 40;

    // Serial clock limits in kHz
    localparam int unsigned SCLK_MAX_KHZ     = 20000;
    localparam int unsigned SCLK_MIN_KHZ     = 10;
    localparam int unsigned SCLK_MIN_EXT_KHZ = 20;

    // Link times as printed, in ns
    localparam int unsigned QUIET_GAP_NS   = 50;
    localparam int unsigned ACQ_WINDOW_NS  = 250;
    localparam int unsigned WAKE_DELAY_NS  = 1000;
    localparam int unsigned SETUP_MIN_NS   = 10;
    localparam int unsigned ENABLE_MAX_NS  = 22;
    localparam int unsigned ACCESS_MAX_NS  = 40;
    localparam int unsigned RELEASE_MAX_NS = 36;

    // Least times round up, longest times round down, never below one cycle
    localparam int unsigned QUIET_GAP_CYC =
        (QUIET_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACQ_WINDOW_CYC =
        (ACQ_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_DELAY_CYC =
        (WAKE_DELAY_NS / CLK_PERIOD_NS > 0) ? WAKE_DELAY_NS / CLK_PERIOD_NS : 1;

    // Counter widths and host pacing
    localparam int unsigned CNT_W  = 4;
    localparam int unsigned WAKE_W = 5;
    localparam logic [CNT_W-1:0] HALF_CYC = 4'h8;
    localparam logic [CNT_W-1:0] GAP_CYC  =
        CNT_W'(ACQ_WINDOW_CYC + QUIET_GAP_CYC);
    localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_DELAY_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

    // Pin synchroniser depth
    localparam int unsigned SYNC_W = 3;

    // Frame layout
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned RES_BITS   = 12;
    localparam int unsigned LEN_W      = 5;
    localparam logic [LEN_W-1:0] LEN_12 = 5'h10;
    localparam logic [LEN_W-1:0] LEN_10 = 5'h0E;
    localparam logic [LEN_W-1:0] LEN_8  = 5'h0C;
    localparam logic [LEN_W-1:0] LEN_ONE = 5'h01;

    // Resolution variants
    typedef enum logic [1:0] {
        SARRD_RES_12,
        SARRD_RES_10,
        SARRD_RES_8
    } sarrd_res_t;

    // Serial clock periods per conversion
    function automatic logic [LEN_W-1:0] sarrd_conv_len(input sarrd_res_t r);
        case (r)
            SARRD_RES_10: sarrd_conv_len = LEN_10;
            SARRD_RES_8:  sarrd_conv_len = LEN_8;
            default:      sarrd_conv_len = LEN_12;
        endcase
    endfunction

    // Outgoing frame: leading zeros, result MSB first, trailing zeros
    function automatic logic [FRAME_BITS-1:0] sarrd_frame(input sarrd_res_t r,
                                                          input logic [RES_BITS-1:0] v);
        case (r)
            SARRD_RES_10: sarrd_frame = {4'h0, v[11:2], 2'h0};
            SARRD_RES_8:  sarrd_frame = {4'h0, v[11:4], 4'h0};
            default:      sarrd_frame = {4'h0, v};
        endcase
    endfunction

    // Right-justified result from the received bits
    function automatic logic [RES_BITS-1:0] sarrd_result(input sarrd_res_t r,
                                                         input logic [FRAME_BITS-1:0] s);
        case (r)
            SARRD_RES_10: sarrd_result = {2'h0, s[9:0]};
            SARRD_RES_8:  sarrd_result = {4'h0, s[7:0]};
            default:      sarrd_result = s[11:0];
        endcase
    endfunction

endpackage

/* File: verification/sarrd_chk.sv */
// Purpose: Timing checks on the link between host and converter ends
// Assumes: Converter output is seen four sampled cycles after a pin edge is seen
// Notes:   Sees only the link wires, the clock and the reset
`timescale 1ns/100ps
`default_nettype none
module sarrd_chk (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Link wires
    input  wire logic select_n,
    input  wire logic serial_clk,
    input  wire logic serial_result_out,
    input  wire logic serial_result_oe
);
    default clocking cb_main @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [4:0] falls_reg;
    logic       sclk_reg;

    // Falls counted per frame; cleared while deselected so aborted frames cannot leak
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            falls_reg <= 5'h00;
            sclk_reg  <= 1'b1;
        end else begin
            sclk_reg <= serial_clk;
            if (select_n)
                falls_reg <= 5'h00;
            else if (sclk_reg && !serial_clk)
                falls_reg <= falls_reg + 5'h01;
        end
    end

    // Line timing relative to select and serial clock edges
    property p_drive_on_select;
        $fell(select_n) |-> ##4 serial_result_oe && !serial_result_out;
    endproperty
    a_drive_on_select: assert property (p_drive_on_select)
        else $error("line not driven with a zero after select fall");
    property p_lead_zero;
        !select_n && $fell(serial_clk) && falls_reg < 5'h03 |-> ##4 !serial_result_out;
    endproperty
    a_lead_zero: assert property (p_lead_zero)
        else $error("leading bit not zero");
    property p_bit_timing;
        serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out)
            |-> $past(serial_clk, 5) && !$past(serial_clk, 4);
    endproperty
    a_bit_timing: assert property (p_bit_timing)
        else $error("data bit changed away from a serial clock fall");
    property p_release_timing;
        $fell(serial_result_oe) && !select_n |-> $past(serial_clk, 5) && !$past(serial_clk, 4);
    endproperty
    a_release_timing: assert property (p_release_timing)
        else $error("line released away from a serial clock fall");
    property p_released_low;
        !serial_result_oe |-> !serial_result_out;
    endproperty
    a_released_low: assert property (p_released_low)
        else $error("released line not low");
    property p_frame_len;
        $fell(serial_result_oe) && !select_n |-> falls_reg inside {5'h0C, 5'h0E, 5'h10};
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame length not 12, 14 or 16 clocks");
    property p_oe_framed;
        serial_result_oe |-> !$past(select_n, 4);
    endproperty
    a_oe_framed: assert property (p_oe_framed)
        else $error("line driven outside the select frame");
    property p_acq_gap;
        $fell(serial_result_oe) |=> (!$fell(select_n))[*7];
    endproperty
    a_acq_gap: assert property (p_acq_gap)
        else $error("next select fall too soon after release");
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Drives host requests and checks results, wire frames and timing
// Assumes: Both ends share clk; converter variant follows the host's
// Notes:   Expected values come from the value and frame length only
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                  clk          = 1'b0;
    logic                  nrst         = 1'b0;
    logic                  start        = 1'b0;
    logic                  power_down   = 1'b0;
    sarrd_pkg::sarrd_res_t variant      = sarrd_pkg::SARRD_RES_12;
    logic [11:0]           sample_value = 12'h000;
    logic [11:0]           result;
    logic                  result_valid;
    logic                  busy;
    logic                  awake;
    logic                  converting;
    logic                  sample_taken;
    logic                  sclk_q       = 1'b1;
    logic [15:0]           rx           = 16'h0000;
    int                    nbits        = 0;
    int                    failures     = 0;
    int                    cmp_count    = 0;
    int                    cycles       = 0;
    int                    k;

    sarrd_link_if link ();

    // Clock
    always #20 clk = ~clk;

    // Both ends and the link checker
    sarrd_device sarrd_device_i (.clk(clk), .nrst(nrst), .link(link), .variant(variant),
        .sample_value(sample_value), .power_down(power_down), .awake(awake),
        .converting(converting), .sample_taken(sample_taken));
    sarrd_host sarrd_host_i (.clk(clk), .nrst(nrst), .link(link), .start(start),
        .variant(variant), .result(result), .result_valid(result_valid), .busy(busy));
    sarrd_chk sarrd_chk_i (.clk(clk), .nrst(nrst), .select_n(link.select_n),
        .serial_clk(link.serial_clk), .serial_result_out(link.serial_result_out),
        .serial_result_oe(link.serial_result_oe));

    // Line bit caught as each clock fall arrives; input scrambled once the sample is held
    always @(posedge clk) begin
        if (!link.select_n && sclk_q && !link.serial_clk) begin
            rx    <= {rx[14:0], link.serial_result_out};
            nbits <= nbits + 1;
        end
        if (sample_taken === 1'b1)
            sample_value <= ~sample_value;
        sclk_q <= link.serial_clk;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One conversion; n is the number of clock periods in the frame
    task automatic run(input sarrd_pkg::sarrd_res_t r, input logic [11:0] v, input int n);
        @(posedge clk);
        variant      <= r;
        sample_value <= v;
        start        <= 1'b1;
        rx = 16'h0000;
        nbits = 0;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        k = 0;
        while (result_valid !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
            // Well inside the frame for every variant
            if (k == 16)
                check({15'h0000, converting}, 16'h0001, "converting");
        end
        check({15'h0000, converting}, 16'h0000, "converting after frame");
        check(16'(k), 16'(16 * n + 8), "answer time");
        check({4'h0, result}, {4'h0, v >> (16 - n)}, "result");
        check(rx, {4'h0, v} >> (16 - n), "wire frame");
        check(16'(nbits), 16'(n), "bit count");
        while (busy === 1'b1 && k < 500) begin
            @(posedge clk);
            k++;
        end
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        k = 0;
        while (awake !== 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        power_down <= 1'b1;
        repeat (4) @(posedge clk);
        check({15'h0000, awake}, 16'h0000, "asleep");
        power_down <= 1'b0;
        @(negedge clk);
        k = 0;
        while (awake !== 1'b1 && k < 60) begin
            @(negedge clk);
            k++;
        end
        check(16'(k <= sarrd_pkg::WAKE_DELAY_CYC + 1), 16'h0001, "wake time");
        run(sarrd_pkg::SARRD_RES_12, 12'hA5C, 16);
        run(sarrd_pkg::SARRD_RES_12, 12'hFFF, 16);
        run(sarrd_pkg::SARRD_RES_10, 12'hC07, 14);
        run(sarrd_pkg::SARRD_RES_8, 12'h5A7, 12);
        run(sarrd_pkg::SARRD_RES_12, 12'h001, 16);
        report_and_stop();
    end
endmodule
`default_nettype wire
